// ===== prio_pkg.sv
// Constants for the interrupt priority register block
package prio_pkg;

  // ----------------------------------------------------------------
  // Bus and register geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;                  // APB address width
  localparam int DATA_W = 32;                 // APB data width
  localparam int REG_W = 16;                  // Register width
  localparam int IDX_W = 6;                   // Word index width
  localparam logic [IDX_W-1:0] TIMER_ABC_IDX = 6'h07;  // Timer A/B/C register index
  localparam logic [IDX_W-1:0] SER0_TMRA_IDX = 6'h08;  // Serial 0 / timer A register index
  localparam logic [IDX_W-1:0] PWM_CONV_IDX = 6'h09;   // PWM / converter register index
  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;   // Value after reset
  localparam logic [REG_W-1:0] WMASK_FULL = 16'hFFFF;  // All bits writable
  localparam logic [REG_W-1:0] WMASK_SER0 = 16'hF3FF;  // Bits 11:10 reserved

  // ----------------------------------------------------------------
  // Source numbering and field encodings
  // ----------------------------------------------------------------
  localparam int SRC_COUNT = 23;              // Sources covered here
  localparam int FLD_W = 2;                   // Priority field width
  localparam logic [1:0] FLD_DISABLED = 2'h0; // Source disabled

  // ----------------------------------------------------------------
  // Field positions (low bit) in each register
  // ----------------------------------------------------------------
  localparam int TIMER_A_CH0_LSB = 14;
  localparam int TIMER_B_CH3_LSB = 12;
  localparam int TIMER_B_CH2_LSB = 10;
  localparam int TIMER_B_CH1_LSB = 8;
  localparam int TIMER_B_CH0_LSB = 6;
  localparam int TIMER_C_CH3_LSB = 4;
  localparam int TIMER_C_CH2_LSB = 2;
  localparam int TIMER_C_CH1_LSB = 0;
  localparam int SER0_RX_FULL_LSB = 14;
  localparam int SER0_RX_ERROR_LSB = 12;
  localparam int SER0_TX_IDLE_LSB = 8;
  localparam int SER0_TX_EMPTY_LSB = 6;
  localparam int TIMER_A_CH3_LSB = 4;
  localparam int TIMER_A_CH2_LSB = 2;
  localparam int TIMER_A_CH1_LSB = 0;
  localparam int PWM_A_FAULT_LSB = 14;
  localparam int PWM_B_FAULT_LSB = 12;
  localparam int PWM_A_RELOAD_LSB = 10;
  localparam int PWM_B_RELOAD_LSB = 8;
  localparam int CONV_A_ZERO_LIMIT_LSB = 6;
  localparam int CONV_B_ZERO_LIMIT_LSB = 4;
  localparam int CONV_A_COMPLETE_LSB = 2;
  localparam int CONV_B_COMPLETE_LSB = 0;

endpackage : prio_pkg

// ===== prio_regs_top.sv
// Interrupt priority registers for timer, serial, PWM and converter sources
`timescale 1ns/100ps
// Operation
// [R1] Field 00 keeps its source disabled, reset value
// [R2] Fields 01/10/11 give levels 0/1/2
// [R3] All fields clear to zero on reset
// [R4] Second register bits 11:10 read zero, unwritable
// [R5] First register 15:14 is timer A channel 0
// [R6] First register 13:6 are timer B channels 3..0
// [R7] First register 5:0 are timer C channels 3..1
// [R8] Second register 15:12 serial receive full, error
// [R9] Second register 9:6 serial transmit idle, empty
// [R10] Second register 5:0 timer A channels 3..1
// [R11] Third register 15:12 PWM A, B fault
// [R12] Third register 11:8 PWM A, B reload
// [R13] Third register 7:6 converter A zero/limit
// [R14] Third register 5:4 converter B zero/limit
// [R15] Third register 3:2 converter A complete
// [R16] Third register 1:0 converter B complete
// [R17] Enabled request presented; disabling withdraws next clock
module prio_regs_top
  import prio_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SRC_COUNT-1:0] src_req,
  output logic [SRC_COUNT-1:0] arb_req,
  output logic [FLD_W*SRC_COUNT-1:0] arb_level
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0] timer_abc_reg;            // Timer A/B/C priorities
  logic [REG_W-1:0] timer_abc_next;
  logic [REG_W-1:0] ser0_tmra_reg;            // Serial 0 / timer A priorities
  logic [REG_W-1:0] ser0_tmra_next;
  logic [REG_W-1:0] pwm_conv_reg;             // PWM / converter priorities
  logic [REG_W-1:0] pwm_conv_next;
  logic [DATA_W-1:0] prdata_reg;              // Read data, loaded in setup
  logic [DATA_W-1:0] prdata_next;
  logic pslverr_reg;                          // Error flag, loaded in setup
  logic pslverr_next;
  logic [SRC_COUNT-1:0] arb_req_reg;          // Requests to arbitration
  logic [SRC_COUNT-1:0] arb_req_next;
  logic [FLD_W*SRC_COUNT-1:0] arb_level_reg;  // Levels to arbitration
  logic [FLD_W*SRC_COUNT-1:0] arb_level_next;
  logic [FLD_W-1:0] src_field [SRC_COUNT];    // Field per source
  logic setup_phase;                          // First cycle of a transfer
  logic write_strobe;                         // Write takes effect now
  logic addr_mapped;                          // Address hits a register
  logic [IDX_W-1:0] word_idx;                 // Word index of address
  logic [DATA_W-1:0] read_mux;                // Selected read value

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Word index from byte address; only aligned words are mapped
  assign word_idx = paddr[ADDR_W-1:2];
  assign addr_mapped = (paddr[1:0] == 2'h0) &&
                       ((word_idx == TIMER_ABC_IDX) ||
                        (word_idx == SER0_TMRA_IDX) ||
                        (word_idx == PWM_CONV_IDX));
  assign setup_phase = psel && !penable;
  // Access phase always completes in one cycle
  assign write_strobe = psel && penable && pwrite && addr_mapped;

  // ----------------------------------------------------------------
  // Byte-lane merge of write data into a register
  // ----------------------------------------------------------------
  function automatic logic [REG_W-1:0] lane_merge(
    input logic [REG_W-1:0] old_val,
    input logic [DATA_W-1:0] wdata,
    input logic [3:0] strb,
    input logic [REG_W-1:0] wmask
  );
    logic [REG_W-1:0] merged;
    merged = old_val;
    // Low byte lane
    if (strb[0]) begin
      merged[7:0] = wdata[7:0];
    end
    // High byte lane
    if (strb[1]) begin
      merged[15:8] = wdata[15:8];
    end
    // Reserved bits stay at zero
    lane_merge = merged & wmask;
  endfunction : lane_merge

  // ----------------------------------------------------------------
  // Priority registers: next values
  // ----------------------------------------------------------------
  always_comb begin
    timer_abc_next = timer_abc_reg;
    ser0_tmra_next = ser0_tmra_reg;
    pwm_conv_next = pwm_conv_reg;
    // Reset clears every field, disabling all sources
    if (reset) begin // [R3]
      timer_abc_next = REG_RESET;
      ser0_tmra_next = REG_RESET;
      pwm_conv_next = REG_RESET;
    end else if (write_strobe) begin
      unique case (word_idx)
        // Timer A/B/C word
        TIMER_ABC_IDX: begin
          timer_abc_next = lane_merge(timer_abc_reg, pwdata, pstrb, WMASK_FULL);
        end
        // Serial 0 / timer A word with reserved pair masked
        SER0_TMRA_IDX: begin // [R4]
          ser0_tmra_next = lane_merge(ser0_tmra_reg, pwdata, pstrb, WMASK_SER0);
        end
        // PWM / converter word
        PWM_CONV_IDX: begin
          pwm_conv_next = lane_merge(pwm_conv_reg, pwdata, pstrb, WMASK_FULL);
        end
        // Unmapped words are never written
        default: begin
          timer_abc_next = timer_abc_reg;
        end
      endcase
    end
  end

  // Priority registers: storage
  always_ff @(posedge core_clk) begin
    timer_abc_reg <= timer_abc_next;
    ser0_tmra_reg <= ser0_tmra_next;
    pwm_conv_reg <= pwm_conv_next;
  end

  // ----------------------------------------------------------------
  // Read path and error flag
  // ----------------------------------------------------------------
  // Read multiplexer; upper bits read as zero
  always_comb begin
    read_mux = '0;
    if (addr_mapped) begin
      if (word_idx == TIMER_ABC_IDX) begin
        read_mux[REG_W-1:0] = timer_abc_reg;
      end else if (word_idx == SER0_TMRA_IDX) begin
        read_mux[REG_W-1:0] = ser0_tmra_reg & WMASK_SER0; // [R4]
      end else begin
        read_mux[REG_W-1:0] = pwm_conv_reg;
      end
    end
  end

  // Capture read data and error in the setup cycle
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (reset) begin
      prdata_next = '0;
      pslverr_next = 1'b0;
    end else if (setup_phase) begin
      // Reads load the word, writes return zero
      prdata_next = pwrite ? '0 : read_mux;
      pslverr_next = !addr_mapped;
    end
  end

  // Read data and error storage
  always_ff @(posedge core_clk) begin
    prdata_reg <= prdata_next;
    pslverr_reg <= pslverr_next;
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;
  // No wait states
  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Field unpacking per source
  // ----------------------------------------------------------------
  always_comb begin
    // timer_a_ch0_priority
    src_field[0] = timer_abc_reg[TIMER_A_CH0_LSB +: FLD_W]; // [R5]
    // timer_b_ch3..ch0_priority
    src_field[1] = timer_abc_reg[TIMER_B_CH3_LSB +: FLD_W]; // [R6]
    src_field[2] = timer_abc_reg[TIMER_B_CH2_LSB +: FLD_W]; // [R6]
    src_field[3] = timer_abc_reg[TIMER_B_CH1_LSB +: FLD_W]; // [R6]
    src_field[4] = timer_abc_reg[TIMER_B_CH0_LSB +: FLD_W]; // [R6]
    // timer_c_ch3..ch1_priority
    src_field[5] = timer_abc_reg[TIMER_C_CH3_LSB +: FLD_W]; // [R7]
    src_field[6] = timer_abc_reg[TIMER_C_CH2_LSB +: FLD_W]; // [R7]
    src_field[7] = timer_abc_reg[TIMER_C_CH1_LSB +: FLD_W]; // [R7]
    // serial0_rx_full / rx_error_priority
    src_field[8] = ser0_tmra_reg[SER0_RX_FULL_LSB +: FLD_W]; // [R8]
    src_field[9] = ser0_tmra_reg[SER0_RX_ERROR_LSB +: FLD_W]; // [R8]
    // serial0_tx_idle / tx_empty_priority
    src_field[10] = ser0_tmra_reg[SER0_TX_IDLE_LSB +: FLD_W]; // [R9]
    src_field[11] = ser0_tmra_reg[SER0_TX_EMPTY_LSB +: FLD_W]; // [R9]
    // timer_a_ch3..ch1_priority
    src_field[12] = ser0_tmra_reg[TIMER_A_CH3_LSB +: FLD_W]; // [R10]
    src_field[13] = ser0_tmra_reg[TIMER_A_CH2_LSB +: FLD_W]; // [R10]
    src_field[14] = ser0_tmra_reg[TIMER_A_CH1_LSB +: FLD_W]; // [R10]
    // pwm_a / pwm_b_fault_priority
    src_field[15] = pwm_conv_reg[PWM_A_FAULT_LSB +: FLD_W]; // [R11]
    src_field[16] = pwm_conv_reg[PWM_B_FAULT_LSB +: FLD_W]; // [R11]
    // pwm_a / pwm_b_reload_priority
    src_field[17] = pwm_conv_reg[PWM_A_RELOAD_LSB +: FLD_W]; // [R12]
    src_field[18] = pwm_conv_reg[PWM_B_RELOAD_LSB +: FLD_W]; // [R12]
    // conv_a_zero_limit_priority
    src_field[19] = pwm_conv_reg[CONV_A_ZERO_LIMIT_LSB +: FLD_W]; // [R13]
    // conv_b_zero_limit_priority
    src_field[20] = pwm_conv_reg[CONV_B_ZERO_LIMIT_LSB +: FLD_W]; // [R14]
    // conv_a_complete_priority
    src_field[21] = pwm_conv_reg[CONV_A_COMPLETE_LSB +: FLD_W]; // [R15]
    // conv_b_complete_priority
    src_field[22] = pwm_conv_reg[CONV_B_COMPLETE_LSB +: FLD_W]; // [R16]
  end

  // ----------------------------------------------------------------
  // Request gating and level encoding per source
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < SRC_COUNT; g++) begin : gen_src
      // Disabled field blocks the request
      assign arb_req_next[g] = !reset && src_req[g] &&
                               (src_field[g] != FLD_DISABLED); // [R1] [R17]
      // Codes 01/10/11 map to levels 0/1/2; idle level is zero
      assign arb_level_next[g*FLD_W +: FLD_W] =
        arb_req_next[g] ? (src_field[g] - 2'h1) : 2'h0; // [R2]
    end
  endgenerate

  // Arbitration outputs storage
  always_ff @(posedge core_clk) begin
    arb_req_reg <= arb_req_next;
    arb_level_reg <= arb_level_next;
  end

  assign arb_req = arb_req_reg;
  assign arb_level = arb_level_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  // Registers come out of reset cleared
  property p_reset_clear;
    $fell(reset) |->
      (timer_abc_reg == 16'h0000) && (ser0_tmra_reg == 16'h0000) &&
      (pwm_conv_reg == 16'h0000) && (arb_req_reg == '0);
  endproperty
  a_reset_clear: assert property (p_reset_clear) // [R3]
    else $error("priority state not cleared after reset");

  // Reserved pair never holds ones
  property p_reserved_hold;
    ser0_tmra_reg[11:10] == 2'h0;
  endproperty
  a_reserved_hold: assert property (p_reserved_hold) // [R4]
    else $error("reserved bits of second register set");

  // Read of second register returns zero in reserved and upper bits
  property p_reserved_read;
    (psel && penable && !pwrite && paddr == {SER0_TMRA_IDX, 2'h0}) |->
      (prdata[11:10] == 2'h0) && (prdata[31:16] == 16'h0000) &&
      (prdata[15:12] == ser0_tmra_reg[15:12]);
  endproperty
  a_reserved_read: assert property (p_reserved_read) // [R4]
    else $error("second register read value wrong");

  // Full-width write to first register stores every field
  property p_write_timer;
    (write_strobe && word_idx == TIMER_ABC_IDX && pstrb[1:0] == 2'h3) |=>
      timer_abc_reg == $past(pwdata[15:0]);
  endproperty
  a_write_timer: assert property (p_write_timer) // [R5] [R6] [R7]
    else $error("first register write not stored");

  // Full-width write to second register stores all but reserved
  property p_write_ser0;
    (write_strobe && word_idx == SER0_TMRA_IDX && pstrb[1:0] == 2'h3) |=>
      ser0_tmra_reg == ($past(pwdata[15:0]) & 16'hF3FF);
  endproperty
  a_write_ser0: assert property (p_write_ser0) // [R8] [R9] [R10]
    else $error("second register write not stored");

  // Full-width write to third register stores every field
  property p_write_pwm;
    (write_strobe && word_idx == PWM_CONV_IDX && pstrb[1:0] == 2'h3) |=>
      pwm_conv_reg == $past(pwdata[15:0]);
  endproperty
  a_write_pwm: assert property (p_write_pwm) // [R11] [R12] [R13] [R14] [R15] [R16]
    else $error("third register write not stored");

  // Unmapped access answers with an error and leaves registers alone
  property p_unmapped;
    (psel && penable && !addr_mapped) |->
      pslverr ##1 $stable(timer_abc_reg) && $stable(ser0_tmra_reg) &&
      $stable(pwm_conv_reg);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");

  // Clearing timer A channel 0 field withdraws its request
  sequence s_clear_ch0;
    write_strobe && word_idx == TIMER_ABC_IDX && pstrb[1] &&
      pwdata[15:14] == 2'h0;
  endsequence
  sequence s_withdrawn_ch0;
    ##2 !arb_req[0];
  endsequence
  property p_withdraw;
    s_clear_ch0 |-> s_withdrawn_ch0;
  endproperty
  a_withdraw: assert property (p_withdraw) // [R17]
    else $error("request not withdrawn after field cleared");

  // Per-source relations between request, field and level
  generate
    for (g = 0; g < SRC_COUNT; g++) begin : gen_chk
      // Disabled source never reaches arbitration
      property p_disabled;
        (src_field[g] == 2'h0) |=> !arb_req[g];
      endproperty
      a_disabled: assert property (p_disabled) // [R1]
        else $error("disabled source reached arbitration");

      // Presented level is field minus one, at most two
      property p_level;
        (src_req[g] && src_field[g] != 2'h0) |=>
          arb_req[g] && (arb_level[g*FLD_W +: FLD_W] <= 2'h2) &&
          (arb_level[g*FLD_W +: FLD_W] == $past(src_field[g]) - 2'h1);
      endproperty
      a_level: assert property (p_level) // [R2] [R17]
        else $error("request or level wrong for enabled source");
    end
  endgenerate

endmodule : prio_regs_top

// ===== prio_src_model.sv
// Far-side model: interrupt source lines and the priority arbiter they feed
`timescale 1ns/100ps
module prio_src_model
  import prio_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [SRC_COUNT-1:0] req_pattern,
  input wire logic [SRC_COUNT-1:0] arb_req,
  input wire logic [FLD_W*SRC_COUNT-1:0] arb_level,
  output logic [SRC_COUNT-1:0] src_req,
  output logic [FLD_W-1:0] top_level,
  output logic top_valid
);
  // ----------------------------------------------------------------
  // Source lines and arbiter result
  // ----------------------------------------------------------------
  logic [SRC_COUNT-1:0] src_reg; // Registered source requests
  logic [SRC_COUNT-1:0] src_next; // Next source requests
  logic [FLD_W-1:0] lvl_reg; // Highest level seen
  logic [FLD_W-1:0] lvl_next; // Next highest level
  logic vld_reg; // Any request presented
  logic vld_next; // Next request flag

  // Sources change only after a clock edge; arbiter keeps the top level
  always_comb begin
    src_next = req_pattern;
    lvl_next = 2'h0;
    vld_next = 1'b0;
    for (int i = 0; i < SRC_COUNT; i++) begin
      if (arb_req[i]) begin
        vld_next = 1'b1;
        if (arb_level[FLD_W*i +: FLD_W] > lvl_next) begin
          lvl_next = arb_level[FLD_W*i +: FLD_W];
        end
      end
    end
  end

  // Registers, cleared by the system reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      src_reg <= '0;
      lvl_reg <= 2'h0;
      vld_reg <= 1'b0;
    end else begin
      src_reg <= src_next;
      lvl_reg <= lvl_next;
      vld_reg <= vld_next;
    end
  end

  assign src_req = src_reg;
  assign top_level = lvl_reg;
  assign top_valid = vld_reg;
endmodule : prio_src_model

// ===== test_irq_priority_regs_7_to_9.sv
// Self-checking testbench for the interrupt priority register block
`timescale 1ns/100ps
module test_irq_priority_regs_7_to_9
  import prio_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [DATA_W-1:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [SRC_COUNT-1:0] req_pattern = '1; // Wanted source lines
  logic [SRC_COUNT-1:0] src_req;
  logic [SRC_COUNT-1:0] arb_req;
  logic [FLD_W*SRC_COUNT-1:0] arb_level;
  logic [FLD_W-1:0] top_level;
  logic top_valid;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;

  prio_regs_top u_prio_regs_top (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
    .arb_req(arb_req), .arb_level(arb_level));

  prio_src_model u_prio_src_model (.core_clk(core_clk), .reset(reset),
    .req_pattern(req_pattern), .arb_req(arb_req), .arb_level(arb_level),
    .src_req(src_req), .top_level(top_level), .top_valid(top_valid));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Cut the run short if it hangs
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
    end
  endtask : check

  // One APB transfer: setup, then access until pready is sampled high
  task automatic apb_xfer(input logic wr, input logic [IDX_W-1:0] idx,
    input logic [DATA_W-1:0] wd, input logic [3:0] st,
    output logic [DATA_W-1:0] rd, output logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the bench timeout ends a wait that never completes
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb_xfer

  task automatic wr_reg(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] d,
    input logic [3:0] st);
    logic [DATA_W-1:0] rd;
    logic err;
    apb_xfer(1'b1, idx, d, st, rd, err);
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [IDX_W-1:0] idx,
    input logic [DATA_W-1:0] exp, input logic exp_err);
    logic [DATA_W-1:0] rd;
    logic err;
    apb_xfer(1'b0, idx, 32'h00000000, 4'h0, rd, err);
    check(name, exp, rd);
    check({name, "_err"}, exp_err, err);
  endtask : rd_chk

  // Register index of each source
  function automatic logic [IDX_W-1:0] src_idx(input int i);
    return (i < 8) ? 6'h07 : (i < 15) ? 6'h08 : 6'h09;
  endfunction : src_idx

  // Low bit of each source's field; bits 11:10 of 0x20 are skipped
  function automatic int src_lsb(input int i);
    int ser[7] = '{14, 12, 8, 6, 4, 2, 0};
    return (i < 8) ? 14 - 2 * i : (i < 15) ? ser[i-8] : 14 - 2 * (i - 15);
  endfunction : src_lsb

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [FLD_W*SRC_COUNT-1:0] exp_lvl;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, all sources held disabled
    for (int r = 7; r < 10; r++) begin
      rd_chk("reset_value", 6'(r), 32'h00000000, 1'b0);
    end
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("arb_req_after_reset", '0, arb_req);
    // Every code of every field, one source at a time
    for (int i = 0; i < SRC_COUNT; i++) begin
      for (int v = 1; v < 4; v++) begin
        wr_reg(src_idx(i), 32'(v) << src_lsb(i), 4'hF);
        // Arbiter model registers the block outputs one cycle later
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check("field_req", 64'(1) << i, arb_req);
        check("field_level", 64'(v - 1) << (2 * i), arb_level);
        check("top_level", v - 1, top_level);
      end
      wr_reg(src_idx(i), 32'h00000000, 4'hF);
      @(negedge core_clk);
      check("withdraw_lag", 64'(1) << i, arb_req);
      @(posedge core_clk);
      @(negedge core_clk);
      check("withdraw", 0, arb_req);
    end
    // Reserved bits, upper data half and full write
    for (int r = 7; r < 10; r++) begin
      wr_reg(6'(r), 32'hFFFFFFFF, 4'hF);
    end
    rd_chk("reg7_full", 6'h07, 32'h0000FFFF, 1'b0);
    rd_chk("reg8_reserved", 6'h08, 32'h0000F3FF, 1'b0);
    rd_chk("reg9_full", 6'h09, 32'h0000FFFF, 1'b0);
    // Only requesting sources reach arbitration, at level 2
    req_pattern <= 23'h2AAAAA;
    exp_lvl = '0;
    for (int i = 1; i < SRC_COUNT; i += 2) begin
      exp_lvl[2*i +: 2] = 2'h2;
    end
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("gated_req", 23'h2AAAAA, arb_req);
    check("gated_level", exp_lvl, arb_level);
    check("top_valid", 1'b1, top_valid);
    // Byte lanes: clear low lane, then write high lane
    wr_reg(6'h07, 32'h00000000, 4'h1);
    rd_chk("lane_low", 6'h07, 32'h0000FF00, 1'b0);
    wr_reg(6'h07, 32'h00001234, 4'h2);
    rd_chk("lane_high", 6'h07, 32'h00001200, 1'b0);
    // Unmapped places answer with an error and read zero
    wr_reg(6'h0A, 32'h0000FFFF, 4'hF);
    rd_chk("unmapped_a", 6'h0A, 32'h00000000, 1'b1);
    rd_chk("unmapped_6", 6'h06, 32'h00000000, 1'b1);
    // Reset in mid-run clears every field again
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    for (int r = 7; r < 10; r++) begin
      rd_chk("rereset_value", 6'(r), 32'h00000000, 1'b0);
    end
    @(negedge core_clk);
    check("rereset_req", 0, arb_req);
    finish_test();
  end
endmodule : test_irq_priority_regs_7_to_9
